// ---- verilog/rev_return_pkg.sv ----
/*
  Constants, enums and carrier structs for the reverse-return speed-change block.
  Assumes a single 100 MHz clock domain and a synchronous active-low reset.
*/
// Summary of operation
// - negative speed change while started: decelerate now, then move opposite way
// - linear or fixed-pitch: return to start point at requested magnitude, then wait
// - circular or helical: the return retraces the arc, not a straight line
// - constant-speed: return to previous path point at requested magnitude, then wait
// - speed mode: reverse at requested magnitude and run until a stop arrives
// - follow-up, speed-switching, jog: plain speed change, error 305, run at limit
// - return speed is the magnitude; above the limit flag 305 and use the limit
// - waiting: start flags held, complete flags low, zero-speed-change flag high
// - positive speed change while waiting restarts the axis
// - stop command while waiting ends the positioning
// - further negative speed changes while waiting are ignored
// - reversed speed mode: positive or negative change flips, stop stops
// - constant-speed: clamp return speed to programmed speed, no error
// - reverse request after automatic deceleration began is refused with error 303
// - constant-speed: ignore reverse request while waiting for mcode finish
// - point passed while decelerating becomes the return target
// - actual speed starts changing within one operation cycle of the request
`default_nettype none
package rev_return_pkg;
  // ==========================================================
  // widths and codes
  localparam int          SPD_W       = 32;
  localparam int          POS_W       = 32;
  localparam logic [15:0] ERR_SPEED   = 16'h0131;  // minor error 305
  localparam logic [15:0] ERR_AFTERDC = 16'h012F;  // minor error 303
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [SPD_W-1:0] SPD_ZERO = 32'h0000_0000;
  // step per cycle the profile stage uses after reset and whenever decelStep is zero
  localparam logic [SPD_W-1:0] DECEL_STEP_RST = 32'h0000_0001;

  // ==========================================================
  // control modes of the running program
  typedef enum logic [2:0] {
    MODE_LINEAR   = 3'b000,
    MODE_CIRCULAR = 3'b001,
    MODE_FEED     = 3'b010,
    MODE_CONST    = 3'b011,
    MODE_SPEED    = 3'b100,
    MODE_FOLLOW   = 3'b101,
    MODE_SWITCH   = 3'b110,
    MODE_JOG      = 3'b111
  } ctrl_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RUN     = 3'b001,
    ST_DECEL   = 3'b010,
    ST_RETURN  = 3'b011,
    ST_WAIT    = 3'b100,
    ST_STOPDEC = 3'b101
  } axis_state_e;

  // speed change request carrier
  typedef struct packed {
    logic             valid;
    logic             negative;
    logic [SPD_W-1:0] magnitude;
  } spd_req_s;

  // axis status flags carrier
  typedef struct packed {
    logic startAccepted;
    logic posStartComplete;
    logic posComplete;
    logic cmdInPosition;
    logic zeroSpeedChangeAccepting;
  } axis_flags_s;
endpackage
`default_nettype wire

// ---- verilog/speed_ramp.sv ----
/*
  Speed ramp stage: moves the actual speed toward a target by a fixed step.
  Assumes target and step come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module speed_ramp
  import rev_return_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [SPD_W-1:0] target,
  input  wire logic [SPD_W-1:0] step,
  output logic      [SPD_W-1:0] speed
);
  logic [SPD_W-1:0] speed_ff;
  logic [SPD_W-1:0] nxt_speed;
  wire  logic [SPD_W-1:0] diffUp = target - speed_ff;
  wire  logic [SPD_W-1:0] diffDn = speed_ff - target;

  // ==========================================================
  // ramp: the first step lands on the cycle after the target moves
  assign nxt_speed = (target > speed_ff) ? ((diffUp > step) ? speed_ff + step : target) :
                     ((diffDn > step) ? speed_ff - step : target);

  always_ff @(posedge clk) begin
    if (!rst_n) speed_ff <= SPD_ZERO;
    else        speed_ff <= nxt_speed;
  end

  assign speed = speed_ff;
endmodule // speed_ramp
`default_nettype wire

// ---- verilog/reverse_return_speed_change.sv ----
/*
  Reverse-return speed-change control for one axis: handles negative speed
  changes, return travel, waiting at the return point, restart and stop.
  Assumes start, request, position and point inputs come from same-clock logic;
  the trajectory generator consumes dirReverse, returnTarget and actualSpeed.
*/
`timescale 1ns/1ps
`default_nettype none
module reverse_return_speed_change
  import rev_return_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             startCmd,        // pulse: program start
  input  wire ctrl_mode_e       mode,            // mode of the started program
  input  wire logic [SPD_W-1:0] progSpeed,       // speed of the program
  input  wire logic [SPD_W-1:0] speedLimit,
  input  wire logic [SPD_W-1:0] decelStep,
  input  wire spd_req_s         speedReq,        // speed_change_instruction
  input  wire logic             stopCmd,
  input  wire logic             autoDecelActive, // automatic decel has begun
  input  wire logic             mcodeFinWait,    // waiting on mcode_finish_handshake
  input  wire logic             moveDone,        // move reached its end
  input  wire logic             atTarget,        // axis reached returnTarget
  input  wire logic [POS_W-1:0] startPoint,
  input  wire logic [POS_W-1:0] prevPoint,
  input  wire logic [POS_W-1:0] passedPoint,
  input  wire logic             passedValid,     // a point was passed in decel
  output axis_flags_s           flags,
  output logic                  dirReverse,
  output logic                  arcRetrace,
  output logic [POS_W-1:0]      returnTarget,
  output logic [SPD_W-1:0]      actualSpeed,
  output logic [15:0]           minorError,
  output logic                  errorPulse
);
  axis_state_e      state_ff, nxt_state;
  logic [SPD_W-1:0] target_ff, nxt_target;
  logic [SPD_W-1:0] retSpeed_ff, nxt_retSpeed;
  logic [POS_W-1:0] retPt_ff, nxt_retPt;
  logic             dir_ff, nxt_dir;
  logic             arc_ff, nxt_arc;
  logic [15:0]      err_ff, nxt_err;
  logic             errP_ff, nxt_errP;
  axis_flags_s      flags_ff, nxt_flags;
  logic [SPD_W-1:0] step_ff;
  logic [SPD_W-1:0] rampSpeed;

  // ==========================================================
  // request decode
  wire logic negReq   = speedReq.valid & speedReq.negative;
  wire logic posReq   = speedReq.valid & ~speedReq.negative;
  wire logic canRet   = (mode != MODE_FOLLOW) & (mode != MODE_SWITCH) & (mode != MODE_JOG);
  wire logic stopMode = (mode == MODE_LINEAR) | (mode == MODE_CIRCULAR) |
                        (mode == MODE_FEED) | (mode == MODE_CONST);
  wire logic overLim  = speedReq.magnitude > speedLimit;
  wire logic overProg = speedReq.magnitude > progSpeed;
  // limit clamp, then constant-speed program clamp without error
  wire logic [SPD_W-1:0] limSpeed = overLim ? speedLimit : speedReq.magnitude;
  wire logic [SPD_W-1:0] cpSpeed  = overProg ? progSpeed : limSpeed;
  wire logic [SPD_W-1:0] reqSpeed = (mode == MODE_CONST) ? cpSpeed : limSpeed;
  wire logic cpErr    = (mode == MODE_CONST) ? (overLim & ~overProg) : overLim;
  // reverse accepted only while running, before auto decel, and in constant-speed mode not in fin wait
  wire logic revIgnore = (mode == MODE_CONST) & mcodeFinWait;
  wire logic revLate   = autoDecelActive;
  wire logic revTake   = negReq & canRet & ~revIgnore & ~revLate;
  wire logic rampDone  = (rampSpeed == SPD_ZERO);
  wire logic [POS_W-1:0] baseRet = (mode == MODE_CONST) ? prevPoint : startPoint;

  // ==========================================================
  // next-state logic; the stop command outranks speed changes
  always_comb begin
    nxt_state    = state_ff;
    nxt_target   = target_ff;
    nxt_retSpeed = retSpeed_ff;
    nxt_retPt    = retPt_ff;
    nxt_dir      = dir_ff;
    nxt_arc      = arc_ff;
    nxt_err      = err_ff;
    nxt_errP     = 1'b0;
    nxt_flags    = flags_ff;
    case (state_ff)
      ST_IDLE: begin
        if (startCmd) begin
          nxt_state  = ST_RUN;
          nxt_target = progSpeed;
          nxt_dir    = 1'b0;
          nxt_arc    = 1'b0;
          nxt_flags  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end
      end
      ST_RUN: begin
        if (stopCmd) begin
          nxt_state  = ST_STOPDEC;
          nxt_target = SPD_ZERO;
        end else if (negReq & ~canRet) begin
          nxt_target = speedLimit;
          nxt_err    = ERR_SPEED;
          nxt_errP   = 1'b1;
        end else if (negReq & canRet & revLate & ~revIgnore) begin
          nxt_err  = ERR_AFTERDC;
          nxt_errP = 1'b1;
        end else if (revTake) begin
          nxt_state    = ST_DECEL;
          nxt_target   = SPD_ZERO;
          nxt_retSpeed = reqSpeed;
          nxt_retPt    = baseRet;
          nxt_arc      = (mode == MODE_CIRCULAR);
          if (cpErr) begin
            nxt_err  = ERR_SPEED;
            nxt_errP = 1'b1;
          end
        end else if (posReq) begin
          nxt_target = limSpeed;
          if (overLim) begin
            nxt_err  = ERR_SPEED;
            nxt_errP = 1'b1;
          end
        end else if (moveDone) begin
          nxt_state  = ST_STOPDEC;
          nxt_target = SPD_ZERO;
        end
      end
      ST_DECEL: begin
        if (passedValid & stopMode) nxt_retPt = passedPoint;
        if (stopCmd) begin
          nxt_state = ST_STOPDEC;
        end else if (rampDone) begin
          nxt_state  = stopMode ? ST_RETURN : ST_RUN;
          nxt_dir    = ~dir_ff;
          nxt_target = retSpeed_ff;
        end
      end
      ST_RETURN: begin
        if (stopCmd) begin
          nxt_state  = ST_STOPDEC;
          nxt_target = SPD_ZERO;
        end else if (atTarget) begin
          nxt_state  = ST_WAIT;
          nxt_target = SPD_ZERO;
          nxt_flags.zeroSpeedChangeAccepting = 1'b1;
        end
      end
      ST_WAIT: begin
        // negative changes are simply dropped here
        if (stopCmd) begin
          nxt_state = ST_IDLE;
          nxt_flags = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
          nxt_arc   = 1'b0;
        end else if (posReq) begin
          nxt_state  = ST_RUN;
          nxt_dir    = 1'b0;
          nxt_arc    = 1'b0;
          nxt_target = limSpeed;
          nxt_flags.zeroSpeedChangeAccepting = 1'b0;
          if (overLim) begin
            nxt_err  = ERR_SPEED;
            nxt_errP = 1'b1;
          end
        end
      end
      ST_STOPDEC: begin
        nxt_target = SPD_ZERO;
        if (rampDone) begin
          nxt_state = ST_IDLE;
          nxt_flags = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
          nxt_arc   = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // in speed mode while running reversed, a change of either sign flips again
    if ((state_ff == ST_RUN) && (mode == MODE_SPEED) && dir_ff && speedReq.valid && !stopCmd) begin
      nxt_state    = ST_DECEL;
      nxt_target   = SPD_ZERO;
      nxt_retSpeed = limSpeed;
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      target_ff   <= SPD_ZERO;
      retSpeed_ff <= SPD_ZERO;
      retPt_ff    <= '0;
      dir_ff      <= 1'b0;
      arc_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      target_ff   <= nxt_target;
      retSpeed_ff <= nxt_retSpeed;
      retPt_ff    <= nxt_retPt;
      dir_ff      <= nxt_dir;
      arc_ff      <= nxt_arc;
    end
  end

  // status, error and step registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_ff   <= ERR_NONE;
      errP_ff  <= 1'b0;
      flags_ff <= '0;
      step_ff  <= DECEL_STEP_RST;
    end else begin
      err_ff   <= nxt_err;
      errP_ff  <= nxt_errP;
      flags_ff <= nxt_flags;
      step_ff  <= (decelStep == SPD_ZERO) ? DECEL_STEP_RST : decelStep;
    end
  end

  // ==========================================================
  // ramp stage; its speed register feeds actualSpeed directly
  speed_ramp u_ramp (
    .clk    (clk),
    .rst_n  (rst_n),
    .target (target_ff),
    .step   (step_ff),
    .speed  (rampSpeed)
  );

  assign flags        = flags_ff;
  assign dirReverse   = dir_ff;
  assign arcRetrace   = arc_ff;
  assign returnTarget = retPt_ff;
  assign actualSpeed  = rampSpeed;
  assign minorError   = err_ff;
  assign errorPulse   = errP_ff;

  // ==========================================================
  // checks
  property p_rev_decel;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_RUN && revTake && !stopCmd && mode != MODE_SPEED)
      |=> (state_ff == ST_DECEL && target_ff == SPD_ZERO);
  endproperty
  a_rev_decel: assert property (p_rev_decel) else $error("reverse did not start decel");

  property p_wait_flags;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_WAIT) |-> (flags.startAccepted && flags.posStartComplete &&
        !flags.posComplete && !flags.cmdInPosition && flags.zeroSpeedChangeAccepting);
  endproperty
  a_wait_flags: assert property (p_wait_flags) else $error("wait flags wrong");

  property p_wait_neg;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_WAIT && negReq && !stopCmd) |=> (state_ff == ST_WAIT);
  endproperty
  a_wait_neg: assert property (p_wait_neg) else $error("negative change left wait");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_WAIT && posReq && !stopCmd) |=> (state_ff == ST_RUN && !dir_ff);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart from wait");

  property p_wait_stop;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_WAIT && stopCmd) |=> (state_ff == ST_IDLE && flags.posComplete);
  endproperty
  a_wait_stop: assert property (p_wait_stop) else $error("stop did not end wait");

  property p_late;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_RUN && negReq && canRet && revLate && !revIgnore && !stopCmd)
      |=> (err_ff == ERR_AFTERDC && state_ff == ST_RUN);
  endproperty
  a_late: assert property (p_late) else $error("late reverse not refused");

  property p_nocan;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_RUN && negReq && !canRet && !stopCmd)
      |=> (err_ff == ERR_SPEED && target_ff == $past(speedLimit) && !dir_ff);
  endproperty
  a_nocan: assert property (p_nocan) else $error("non-return mode mishandled");

  property p_finwait;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_RUN && negReq && mode == MODE_CONST && mcodeFinWait && !stopCmd)
      |=> (state_ff == ST_RUN);
  endproperty
  a_finwait: assert property (p_finwait) else $error("reverse in fin wait taken");

  property p_cpclamp;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_RUN && revTake && mode == MODE_CONST && overProg && !stopCmd)
      |=> (retSpeed_ff == $past(progSpeed) && !errP_ff);
  endproperty
  a_cpclamp: assert property (p_cpclamp) else $error("constant speed clamp wrong");

  property p_ramp;
    @(posedge clk) disable iff (!rst_n)
      (target_ff != rampSpeed) |=> (rampSpeed != $past(rampSpeed));
  endproperty
  a_ramp: assert property (p_ramp) else $error("speed did not move in one cycle");

  // end of a reversing decel: the next edge must flip direction and load the return speed
  sequence s_decel_end;
    (state_ff == ST_DECEL) && rampDone && !stopCmd;
  endsequence

  property p_flip;
    @(posedge clk) disable iff (!rst_n)
      s_decel_end |=> ((dir_ff != $past(dir_ff)) && (target_ff == $past(retSpeed_ff)));
  endproperty
  a_flip: assert property (p_flip) else $error("no reversal after decel");
endmodule // reverse_return_speed_change
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the reverse-return speed-change block: one task per scenario.
  Assumes the design's own assertions sit in its files; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rev_return_pkg::*;
  logic             clk, rst_n, startCmd, stopCmd, autoDecelActive, mcodeFinWait;
  logic             moveDone, atTarget, passedValid, dirReverse, arcRetrace, errorPulse;
  ctrl_mode_e       mode;
  logic [SPD_W-1:0] progSpeed, speedLimit, decelStep, actualSpeed;
  logic [POS_W-1:0] startPoint, prevPoint, passedPoint, returnTarget;
  spd_req_s         speedReq;
  axis_flags_s      flags;
  logic [15:0]      minorError;
  int               n_fail, comparisons, cycles;
  bit               errSeen;

  reverse_return_speed_change dut_u (.clk(clk), .rst_n(rst_n), .startCmd(startCmd),
    .mode(mode), .progSpeed(progSpeed), .speedLimit(speedLimit), .decelStep(decelStep),
    .speedReq(speedReq), .stopCmd(stopCmd), .autoDecelActive(autoDecelActive),
    .mcodeFinWait(mcodeFinWait), .moveDone(moveDone), .atTarget(atTarget),
    .startPoint(startPoint), .prevPoint(prevPoint), .passedPoint(passedPoint),
    .passedValid(passedValid), .flags(flags), .dirReverse(dirReverse),
    .arcRetrace(arcRetrace), .returnTarget(returnTarget), .actualSpeed(actualSpeed),
    .minorError(minorError), .errorPulse(errorPulse));

  // ==========================================================
  // clock and hang guard; 20000 cycles is far above the whole run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input bit ok, input string msg);
    comparisons = comparisons + 1;
    if (!ok) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t ns: %s", $time, msg);
    end
  endtask

  // every scenario starts from a fresh reset so no state leaks between them
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0; startCmd = 1'b0; stopCmd = 1'b0; autoDecelActive = 1'b0;
    mcodeFinWait = 1'b0; moveDone = 1'b0; atTarget = 1'b0; passedValid = 1'b0;
    mode = MODE_LINEAR; progSpeed = 32'h0000_0014; speedLimit = 32'h0000_0064;
    decelStep = 32'h0000_0005; speedReq = '0; startPoint = 32'h0000_0A00;
    prevPoint = 32'h0000_0B00; passedPoint = 32'h0000_0C00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // sel 0: speed, 1: direction, 2: zero-change flag, 3: positioning complete
  task automatic wait_sig(input int sel, input logic [31:0] v);
    int i;
    bit hit;
    hit = 1'b0;
    for (i = 0; i < 400 && !hit; i++) begin
      hit = (sel == 0) ? (actualSpeed === v) : (sel == 1) ? (dirReverse === v[0]) :
            (sel == 2) ? (flags.zeroSpeedChangeAccepting === v[0]) : (flags.posComplete === v[0]);
      if (!hit) @(negedge clk);
    end
    check(hit, "bounded wait ran out");
  endtask

  task automatic start_axis(input ctrl_mode_e m, input logic [31:0] prog, input logic [31:0] lim);
    do_reset();
    mode = m; progSpeed = prog; speedLimit = lim;
    startCmd = 1'b1;
    @(negedge clk);
    startCmd = 1'b0;
    wait_sig(0, prog);
    check(flags.posStartComplete === 1'b1, "start not complete before change");
  endtask

  // one-cycle request, then watch four cycles for the error pulse
  task automatic req(input logic neg, input logic [31:0] mag);
    speedReq = '{valid: 1'b1, negative: neg, magnitude: mag};
    @(negedge clk);
    speedReq.valid = 1'b0;
    // the error pulse stands only in the first cycle after the request edge
    errSeen = (errorPulse === 1'b1);
    repeat (3) begin
      @(negedge clk);
      errSeen = errSeen | (errorPulse === 1'b1);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_linear_return();
    ctrl_mode_e m[3] = '{MODE_LINEAR, MODE_CIRCULAR, MODE_FEED};
    foreach (m[k]) begin
      start_axis(m[k], 32'h0000_0014, 32'h0000_0064);
      req(1'b1, 32'h0000_0008);
      check(actualSpeed !== 32'h0000_0014, "speed did not start falling");
      check(returnTarget === startPoint, "return target not start point");
      wait_sig(1, 32'h1);
      wait_sig(0, 32'h0000_0008);
      check(arcRetrace === (m[k] == MODE_CIRCULAR), "arc retrace wrong");
      atTarget = 1'b1;
      wait_sig(2, 32'h1);
      atTarget = 1'b0;
      check(flags.startAccepted === 1'b1 && flags.posStartComplete === 1'b1, "start flags");
      check(flags.posComplete === 1'b0 && flags.cmdInPosition === 1'b0, "done flags");
      req(1'b1, 32'h0000_0009);
      check(flags.zeroSpeedChangeAccepting === 1'b1 && !errSeen, "negative in wait acted");
    end
    req(1'b0, 32'h0000_000A);
    check(dirReverse === 1'b0 && flags.zeroSpeedChangeAccepting === 1'b0, "no restart");
    wait_sig(0, 32'h0000_000A);
    $display("test linear_return done");
  endtask

  task automatic t_stop_in_wait();
    start_axis(MODE_LINEAR, 32'h0000_0014, 32'h0000_0064);
    req(1'b1, 32'h0000_0008);
    wait_sig(0, 32'h0000_0008);
    atTarget = 1'b1;
    wait_sig(2, 32'h1);
    stopCmd = 1'b1;
    wait_sig(3, 32'h1);
    check(flags.cmdInPosition === 1'b1 && flags.startAccepted === 1'b0, "stop end flags");
    stopCmd = 1'b0;
    $display("test stop_in_wait done");
  endtask

  task automatic t_const_clamp_passed();
    start_axis(MODE_CONST, 32'h0000_0014, 32'h0000_0064);
    req(1'b1, 32'h0000_0032);
    check(returnTarget === prevPoint && !errSeen, "const return target or error");
    passedValid = 1'b1;
    @(negedge clk);
    passedValid = 1'b0;
    @(negedge clk);
    check(returnTarget === passedPoint, "passed point not taken");
    wait_sig(1, 32'h1);
    wait_sig(0, 32'h0000_0014);
    check(minorError === 16'h0000, "clamp raised an error");
    atTarget = 1'b1;
    wait_sig(2, 32'h1);
    $display("test const_clamp_passed done");
  endtask

  task automatic t_over_limit();
    start_axis(MODE_LINEAR, 32'h0000_000A, 32'h0000_000F);
    req(1'b1, 32'h0000_001E);
    check(errSeen && minorError === 16'h0131, "no error 305");
    wait_sig(1, 32'h1);
    wait_sig(0, 32'h0000_000F);
    $display("test over_limit done");
  endtask

  task automatic t_refusals();
    start_axis(MODE_LINEAR, 32'h0000_0014, 32'h0000_0064);
    autoDecelActive = 1'b1;
    req(1'b1, 32'h0000_0008);
    check(errSeen && minorError === 16'h012F, "no error 303");
    repeat (10) @(negedge clk);
    check(dirReverse === 1'b0, "reversed after auto decel");
    start_axis(MODE_CONST, 32'h0000_0014, 32'h0000_0064);
    mcodeFinWait = 1'b1;
    req(1'b1, 32'h0000_0008);
    repeat (10) @(negedge clk);
    check(dirReverse === 1'b0 && !errSeen, "acted during mcode wait");
    $display("test refusals done");
  endtask

  task automatic t_speed_mode();
    start_axis(MODE_SPEED, 32'h0000_0014, 32'h0000_0064);
    req(1'b1, 32'h0000_0008);
    wait_sig(1, 32'h1);
    wait_sig(0, 32'h0000_0008);
    repeat (5) @(negedge clk);
    check(flags.zeroSpeedChangeAccepting === 1'b0 && actualSpeed === 32'h0000_0008, "halted");
    req(1'b0, 32'h0000_000C);
    wait_sig(1, 32'h0);
    wait_sig(0, 32'h0000_000C);
    req(1'b1, 32'h0000_0006);
    wait_sig(1, 32'h1);
    wait_sig(0, 32'h0000_0006);
    req(1'b1, 32'h0000_0007);
    wait_sig(1, 32'h0);
    wait_sig(0, 32'h0000_0007);
    stopCmd = 1'b1;
    wait_sig(0, 32'h0);
    wait_sig(3, 32'h1);
    stopCmd = 1'b0;
    $display("test speed_mode done");
  endtask

  task automatic t_no_return_modes();
    ctrl_mode_e m[3] = '{MODE_FOLLOW, MODE_SWITCH, MODE_JOG};
    foreach (m[k]) begin
      start_axis(m[k], 32'h0000_000A, 32'h0000_001E);
      req(1'b1, 32'h0000_0005);
      check(errSeen && minorError === 16'h0131, "no error 305");
      wait_sig(0, 32'h0000_001E);
      check(dirReverse === 1'b0, "reversed in plain mode");
    end
    $display("test no_return_modes done");
  endtask

  // ==========================================================
  // closing report, reached from the main sequence or the hang guard
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    n_fail = 0; comparisons = 0; cycles = 0; rst_n = 1'b0;
    t_linear_return();
    t_stop_in_wait();
    t_const_clamp_passed();
    t_over_limit();
    t_refusals();
    t_speed_mode();
    t_no_return_modes();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
